// [mvt_tag_detect.sv]
// Tag identifier registers, receive tag detection and pause busy flag, AHB-Lite slave
`timescale 1ns/1ps
`include "mvt_cfg.svh"

module mvt_tag_detect #(
   parameter int SYNC_W = 10
) (
   input  wire logic        CLK,              // 20 MHz clock
   input  wire logic        RST,              // Async reset, active high
   input  wire logic        HSEL,             // Slave select
   input  wire logic [31:0] HADDR,            // Byte address
   input  wire logic [1:0]  HTRANS,           // Transfer type
   input  wire logic        HWRITE,           // Write when high
   input  wire logic [2:0]  HSIZE,            // Transfer size, word only
   input  wire logic [31:0] HWDATA,           // Write data
   input  wire logic        HREADY,           // Bus ready
   output logic      [31:0] HRDATA,           // Read data
   output logic             HREADYOUT,        // Slave ready
   output logic             HRESP,            // Always OKAY
   input  wire logic        RX_FRAME,         // Frame in progress, from PHY
   input  wire logic        RX_BYTE_TGL,      // Toggles once per byte
   input  wire logic [7:0]  RX_BYTE,          // Received byte
   input  wire logic        PAUSE_TX_DONE,    // Pause frame sent, pulse
   input  wire logic        BACKPRESSURE,     // Backpressure being applied
   output logic             PAUSE_SEND_REQ,   // Start pause frame, pulse
   output logic             PAUSE_BUSY,       // Busy flag copy
   output logic             RX_DONE,          // Frame judged, pulse
   output logic             RX_TAG1,          // Last frame matched first tag
   output logic             RX_TAG2,          // Last frame matched second tag
   output logic             RX_OVERSIZE       // Last frame too long
);

   // ****************************************
   // Register bus
   // ****************************************
   mvt_pkg::mvt_ahb_phase_s dp;
   logic [15:0]             first_tag_value;
   logic [15:0]             second_tag_value;
   logic                    pause_send_busy_flag;
   mvt_pkg::mvt_rx_result_s res;
   logic [31:0]             next_rdata;
   logic                    ap_valid;
   logic [7:0]              ap_idx;
   logic                    wr_tag1;
   logic                    wr_tag2;
   logic                    wr_pause;

   assign ap_valid = HSEL & HREADY & HTRANS[1];
   assign ap_idx   = HADDR[9:2];
   assign wr_tag1  = dp.valid & dp.write & (dp.idx == `MVT_IDX_TAG1);
   assign wr_tag2  = dp.valid & dp.write & (dp.idx == `MVT_IDX_TAG2);
   assign wr_pause = dp.valid & dp.write & (dp.idx == `MVT_IDX_PAUSE);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dp <= '0;
      end else if (HREADY) begin
         dp.valid <= ap_valid;
         dp.write <= HWRITE;
         dp.idx   <= ap_idx;
      end
   end

   // Read data is latched in the address phase; a write still in its data
   // phase to the same tag register is forwarded so tag register reads never see stale data.
   always_comb begin
      next_rdata = `MVT_ZERO_WORD;
      if (ap_idx == `MVT_IDX_TAG1) begin
         next_rdata[15:0] = wr_tag1 ? HWDATA[15:0] : first_tag_value;
      end else if (ap_idx == `MVT_IDX_TAG2) begin
         next_rdata[15:0] = wr_tag2 ? HWDATA[15:0] : second_tag_value;
      end else if (ap_idx == `MVT_IDX_PAUSE) begin
         next_rdata[`MVT_PAUSE_BUSY] = pause_send_busy_flag;
      end else if (ap_idx == `MVT_IDX_RXSTAT) begin
         next_rdata[`MVT_STAT_TAG1]  = res.tag1;
         next_rdata[`MVT_STAT_TAG2]  = res.tag2;
         next_rdata[`MVT_STAT_OVER]  = res.oversize;
         next_rdata[27:16]           = res.length;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         HRDATA    <= `MVT_ZERO_WORD;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else if (ap_valid && !HWRITE) begin
         HRDATA <= next_rdata;
      end
   end

   // Reserved high bits are never stored
   // reset zero, low half
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         first_tag_value  <= `MVT_TAG_RST;
         second_tag_value <= `MVT_TAG_RST;
      end else begin
         if (wr_tag1) begin
            first_tag_value <= HWDATA[15:0];
         end
         if (wr_tag2) begin
            second_tag_value <= HWDATA[15:0];
         end
      end
   end

   // ****************************************
   // Pause busy flag
   // ****************************************
   mvt_pkg::mvt_pause_state_e pause_state;
   mvt_pkg::mvt_pause_state_e next_pause_state;
   logic                      send_start;

   assign send_start = wr_pause & HWDATA[`MVT_PAUSE_SEND] & ~pause_send_busy_flag;

   always_comb begin
      next_pause_state = pause_state;
      case (pause_state)
         mvt_pkg::PS_IDLE: begin
            if (send_start) begin
               next_pause_state = mvt_pkg::PS_SEND;
            end
         end
         mvt_pkg::PS_SEND: begin
            if (PAUSE_TX_DONE) begin
               next_pause_state = mvt_pkg::PS_IDLE;
            end
         end
         default: next_pause_state = mvt_pkg::PS_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pause_state          <= mvt_pkg::PS_IDLE;
         pause_send_busy_flag <= 1'b0;
         PAUSE_BUSY           <= 1'b0;
         PAUSE_SEND_REQ       <= 1'b0;
      end else begin
         pause_state          <= next_pause_state;
         pause_send_busy_flag <= (next_pause_state == mvt_pkg::PS_SEND) | BACKPRESSURE;
         PAUSE_BUSY           <= (next_pause_state == mvt_pkg::PS_SEND) | BACKPRESSURE;
         PAUSE_SEND_REQ       <= send_start;
      end
   end

   // ****************************************
   // Receive input synchroniser
   // ****************************************
   logic [SYNC_W-1:0] s1;
   logic [SYNC_W-1:0] s2;
   logic [SYNC_W-1:0] s3;
   logic              frame_q;
   logic              tgl_q;
   logic              byte_evt;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= {RX_FRAME, RX_BYTE_TGL, RX_BYTE};
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A level is taken only once stages two and three agree
   assign byte_evt = (s2[8] == s3[8]) & (s3[8] != tgl_q);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         frame_q <= 1'b0;
         tgl_q   <= 1'b0;
      end else begin
         if (s2[9] == s3[9]) begin
            frame_q <= s3[9];
         end
         if (s2[8] == s3[8]) begin
            tgl_q <= s3[8];
         end
      end
   end

   // ****************************************
   // Frame tracking and tag detection
   // ****************************************
   mvt_pkg::mvt_rx_state_e rx_state;
   logic [11:0]            cnt;
   logic [15:0]            type_field;
   logic                   hit1;
   logic                   hit2;
   logic [11:0]            limit;

   assign hit1  = (cnt >= `MVT_TYPE_END) & (type_field == first_tag_value);
   assign hit2  = (cnt >= `MVT_TYPE_END) & (type_field == second_tag_value);
   assign limit = (hit1 | hit2) ? `MVT_LEN_TAGGED : `MVT_LEN_PLAIN;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rx_state <= mvt_pkg::RX_IDLE;
      end else begin
         case (rx_state)
            mvt_pkg::RX_IDLE:  rx_state <= frame_q ? mvt_pkg::RX_FRAME : mvt_pkg::RX_IDLE;
            mvt_pkg::RX_FRAME: rx_state <= frame_q ? mvt_pkg::RX_FRAME : mvt_pkg::RX_END;
            default:           rx_state <= mvt_pkg::RX_IDLE;
         endcase
      end
   end

   // Count saturates so very long frames still read as oversize
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cnt        <= '0;
         type_field <= '0;
      end else if (rx_state == mvt_pkg::RX_IDLE && !frame_q) begin
         cnt        <= '0;
         type_field <= '0;
      end else if (byte_evt && frame_q) begin
         if (cnt == `MVT_TYPE_HI_POS) begin
            type_field[15:8] <= s3[7:0];
         end
         if (cnt == `MVT_TYPE_LO_POS) begin
            type_field[7:0] <= s3[7:0];
         end
         if (cnt != `MVT_LEN_MAX) begin
            cnt <= cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         res         <= '0;
         RX_DONE     <= 1'b0;
         RX_TAG1     <= 1'b0;
         RX_TAG2     <= 1'b0;
         RX_OVERSIZE <= 1'b0;
      end else begin
         RX_DONE <= (rx_state == mvt_pkg::RX_END);
         if (rx_state == mvt_pkg::RX_END) begin
            res.tag1     <= hit1;
            res.tag2     <= hit2;
            res.oversize <= cnt > limit;
            res.length   <= cnt;
            RX_TAG1      <= hit1;
            RX_TAG2      <= hit2;
            RX_OVERSIZE  <= cnt > limit;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_busy_on_send;
      send_start |=> pause_send_busy_flag && PAUSE_SEND_REQ;
   endproperty
   a_busy_on_send: assert property (p_busy_on_send)
      else $error("busy not set on pause send");

   property p_busy_clear;
      pause_state == mvt_pkg::PS_SEND && PAUSE_TX_DONE && !BACKPRESSURE
         |=> !pause_send_busy_flag && pause_state == mvt_pkg::PS_IDLE;
   endproperty
   a_busy_clear: assert property (p_busy_clear)
      else $error("busy not cleared after pause");

   property p_busy_hold;
      pause_state == mvt_pkg::PS_SEND && !PAUSE_TX_DONE |=> pause_send_busy_flag;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped during pause");

   property p_tag1;
      rx_state == mvt_pkg::RX_END
         |=> RX_DONE && RX_TAG1 == ($past(cnt) >= `MVT_TYPE_END
             && $past(type_field) == first_tag_value);
   endproperty
   a_tag1: assert property (p_tag1)
      else $error("first tag result wrong");

   property p_tag2;
      rx_state == mvt_pkg::RX_END
         |=> RX_TAG2 == ($past(cnt) >= `MVT_TYPE_END
             && $past(type_field) == second_tag_value);
   endproperty
   a_tag2: assert property (p_tag2)
      else $error("second tag result wrong");

   property p_len_limit;
      RX_DONE |-> RX_OVERSIZE == (res.length >
         ((RX_TAG1 || RX_TAG2) ? `MVT_LEN_TAGGED : `MVT_LEN_PLAIN));
   endproperty
   a_len_limit: assert property (p_len_limit)
      else $error("oversize judged on wrong limit");

   property p_reserved_zero;
      ap_valid && !HWRITE && (ap_idx == `MVT_IDX_TAG1 || ap_idx == `MVT_IDX_TAG2)
         |=> HRDATA[31:16] == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved tag bits not zero");

   property p_tag_write;
      wr_tag1 |=> first_tag_value == $past(HWDATA[15:0]);
   endproperty
   a_tag_write: assert property (p_tag_write)
      else $error("first tag write lost");

endmodule // mvt_tag_detect

// [mvt_cfg.svh]
// Register offsets, field positions, reset values and frame limits of the tag detector
`ifndef MVT_CFG_SVH
`define MVT_CFG_SVH
// Register indexes; byte address is four times the index
`define MVT_IDX_PAUSE     8'h08
`define MVT_IDX_TAG1      8'h09
`define MVT_IDX_TAG2      8'h0A
`define MVT_IDX_RXSTAT    8'h10
// Pause control fields
`define MVT_PAUSE_BUSY    0
`define MVT_PAUSE_SEND    1
// Receive status fields
`define MVT_STAT_TAG1     0
`define MVT_STAT_TAG2     1
`define MVT_STAT_OVER     2
`define MVT_STAT_LEN_LO   16
// Reset values
`define MVT_TAG_RST       16'h0000
`define MVT_ZERO_WORD     32'h0000_0000
// Frame limits and type field position (byte counts from zero)
`define MVT_LEN_PLAIN     12'h5EE
`define MVT_LEN_TAGGED    12'h5F2
`define MVT_TYPE_HI_POS   12'h00C
`define MVT_TYPE_LO_POS   12'h00D
`define MVT_TYPE_END      12'h00E
`define MVT_LEN_MAX       12'hFFF
`endif

// [mvt_pkg.sv]
// Types shared by the tag detector
package mvt_pkg;
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_FRAME = 3'b010,
      RX_END   = 3'b100
   } mvt_rx_state_e;
   typedef enum logic [1:0] {
      PS_IDLE = 2'b01,
      PS_SEND = 2'b10
   } mvt_pause_state_e;
   typedef struct packed {
      logic        tag1;
      logic        tag2;
      logic        oversize;
      logic [11:0] length;
   } mvt_rx_result_s;
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] idx;
   } mvt_ahb_phase_s;
endpackage

// [mvt_phy_model.sv]
// Behavioural receive side of the PHY that feeds frames to the tag detector
`timescale 1ns/1ps
module mvt_phy_model (
   input  wire logic       CLK,          // Same clock as the detector
   output logic            RX_FRAME,     // Frame in progress
   output logic            RX_BYTE_TGL,  // Toggles once per byte
   output logic [7:0]      RX_BYTE       // Byte value
);
   // ************************************
   // Frame source
   // ************************************
   initial begin
      RX_FRAME    = 1'b0;
      RX_BYTE_TGL = 1'b0;
      RX_BYTE     = 8'h00;
   end
   // Gap of at least four cycles keeps each byte stable past the synchroniser
   task automatic send(input int len, input logic [15:0] typ, input int gap);
      @(posedge CLK);
      RX_FRAME <= 1'b1;
      for (int i = 0; i < len; i++) begin
         repeat (gap) @(posedge CLK);
         RX_BYTE     <= (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : i[7:0] ^ 8'ha5;
         RX_BYTE_TGL <= ~RX_BYTE_TGL;
      end
      repeat (gap) @(posedge CLK);
      RX_FRAME <= 1'b0;
      // Stale byte is not left on the lines after the frame
      RX_BYTE  <= ~RX_BYTE;
   endtask
endmodule // mvt_phy_model

// [mvt_tag_detect_tb.sv]
// Self-checking bench for the tag detector
`timescale 1ns/1ps
`include "mvt_cfg.svh"
module mvt_tag_detect_tb;
   // ************************************
   // Signals and instances
   // ************************************
   logic        clk, rst, hsel, hwrite, pause_tx_done, backpressure;
   logic [31:0] haddr, hwdata, rd, lfsr, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, pause_send_req, pause_busy, rx_done;
   logic        rx_tag1, rx_tag2, rx_oversize, rx_frame, rx_byte_tgl;
   logic [7:0]  rx_byte;
   logic [15:0] t1, t2;
   int          err_total, cmp_count;
   int          req_cnt = 0;

   mvt_tag_detect dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .RX_FRAME(rx_frame), .RX_BYTE_TGL(rx_byte_tgl),
      .RX_BYTE(rx_byte), .PAUSE_TX_DONE(pause_tx_done), .BACKPRESSURE(backpressure),
      .PAUSE_SEND_REQ(pause_send_req), .PAUSE_BUSY(pause_busy), .RX_DONE(rx_done),
      .RX_TAG1(rx_tag1), .RX_TAG2(rx_tag2), .RX_OVERSIZE(rx_oversize));
   mvt_phy_model phy (.CLK(clk), .RX_FRAME(rx_frame), .RX_BYTE_TGL(rx_byte_tgl),
      .RX_BYTE(rx_byte));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) if (pause_send_req === 1'b1) req_cnt <= req_cnt + 1;

   // ************************************
   // Helpers
   // ************************************
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_stat(input int len, input logic [15:0] typ);
      logic m1, m2;
      m1 = (len >= 14) && (typ == t1);
      m2 = (len >= 14) && (typ == t2);
      return {4'h0, len[11:0], 13'h0, len > ((m1 || m2) ? 1522 : 1518), m2, m1};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Single word transfer; waits on the slave's ready at each phase
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rdv);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
      // Slave must always answer OKAY
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic frame(input int len, input logic [15:0] typ);
      logic [31:0] e;
      int n;
      e = exp_stat(len, typ);
      phy.send(len, typ, 4 + (len & 1));
      n = 0;
      while (rx_done !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk({28'h0, rx_done, rx_oversize, rx_tag2, rx_tag1},
          {28'h0, 1'b1, e[2:0]});
      bus(1'b0, `MVT_IDX_RXSTAT, 32'h0, rd);
      chk(rd, e);
   endtask
   task stop_test;
      $display("Counts: %0d mismatches in %0d comparisons", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      stop_test();
   end

   // ************************************
   // Tests
   // ************************************
   initial begin
      rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = 32'h0; pause_tx_done = 1'b0; backpressure = 1'b0;
      lfsr = 32'h4ad2_a63f; err_total = 0; cmp_count = 0; t1 = 16'h0; t2 = 16'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, `MVT_IDX_TAG1, 32'h0, rd);
      chk(rd, `MVT_ZERO_WORD);
      bus(1'b0, `MVT_IDX_TAG2, 32'h0, rd);
      chk(rd, `MVT_ZERO_WORD);
      bus(1'b0, 8'h33, 32'h0, rd);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_step(lfsr);
         bus(1'b1, i[0] ? `MVT_IDX_TAG2 : `MVT_IDX_TAG1, lfsr, rd);
         bus(1'b0, i[0] ? `MVT_IDX_TAG2 : `MVT_IDX_TAG1, 32'h0, rd);
         chk(rd, {16'h0, lfsr[15:0]});
      end
      $display("Register test done");
      // Swapping which register holds the tag tells the two compares apart
      for (int p = 0; p < 2; p++) begin
         t1 = p ? 16'h0000 : 16'h8100;
         t2 = p ? 16'h8100 : 16'h0000;
         lfsr = lfsr_step(lfsr);
         bus(1'b1, `MVT_IDX_TAG1, {lfsr[31:16], t1}, rd);
         bus(1'b1, `MVT_IDX_TAG2, {lfsr[15:0], t2}, rd);
         frame(1523, 16'h8100);
         frame(14, 16'h0000);
         frame(13, 16'h8100);
         if (p == 0) begin
            frame(1522, 16'h8100);
            frame(1518, 16'h0800);
            frame(1519, 16'h0800);
         end
         for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_step(lfsr);
            frame(14 + lfsr[5:0], lfsr[6] ? 16'h8100 : lfsr[23:8]);
         end
      end
      $display("Receive test done");
      bus(1'b0, `MVT_IDX_PAUSE, 32'h0, rd);
      chk(rd & 32'h1, 32'h0);
      bus(1'b1, `MVT_IDX_PAUSE, 32'h2, rd);
      repeat (2) @(negedge clk);
      chk({30'h0, pause_busy, req_cnt == 1}, 32'h3);
      bus(1'b0, `MVT_IDX_PAUSE, 32'h0, rd);
      chk(rd & 32'h1, 32'h1);
      @(posedge clk) pause_tx_done <= 1'b1;
      @(posedge clk) pause_tx_done <= 1'b0;
      repeat (2) @(negedge clk);
      chk({31'h0, pause_busy}, 32'h0);
      @(posedge clk) backpressure <= 1'b1;
      repeat (3) @(negedge clk);
      chk({31'h0, pause_busy}, 32'h1);
      @(posedge clk) pause_tx_done <= 1'b1;
      @(posedge clk) pause_tx_done <= 1'b0;
      repeat (2) @(negedge clk);
      chk({31'h0, pause_busy}, 32'h1);
      @(posedge clk) backpressure <= 1'b0;
      repeat (3) @(negedge clk);
      bus(1'b0, `MVT_IDX_PAUSE, 32'h0, rd);
      // Exactly one send request over the whole run
      chk({30'h0, req_cnt == 1, pause_busy} | (rd & 32'h1), 32'h2);
      $display("Pause test done");
      stop_test();
   end
endmodule // mvt_tag_detect_tb
